// ---- design/rpis_defines.vh ----
// Offsets, field positions, reset values and masks for the remappable input select registers
`ifndef RPIS_DEFINES_VH
`define RPIS_DEFINES_VH

// Register indices (byte address is four times the index)
`define RPIS_IDX_CAP56     4'd9
`define RPIS_IDX_CAP7      4'd10
`define RPIS_IDX_FAULT     4'd11
`define RPIS_IDX_SER3RX    5'd17
`define RPIS_IDX_SER1      5'd18
`define RPIS_IDX_SER2      5'd19
`define RPIS_IDX_SPI1CD    5'd20
`define RPIS_IDX_SER3SPI   5'd21

// Byte addresses
`define RPIS_ADDR_CAP56    12'h024
`define RPIS_ADDR_CAP7     12'h028
`define RPIS_ADDR_FAULT    12'h02C
`define RPIS_ADDR_SER3RX   12'h044
`define RPIS_ADDR_SER1     12'h048
`define RPIS_ADDR_SER2     12'h04C
`define RPIS_ADDR_SPI1CD   12'h050
`define RPIS_ADDR_SER3SPI  12'h054

// Field positions
`define RPIS_HI_MSB        13
`define RPIS_HI_LSB        8
`define RPIS_LO_MSB        5
`define RPIS_LO_LSB        0

// Field width and reset value
`define RPIS_SEL_W         6
`define RPIS_SEL_RST       6'h3F

// Read masks: which bits each register implements
`define RPIS_MASK_BOTH     16'h3F3F
`define RPIS_MASK_LO       16'h003F
`define RPIS_MASK_HI       16'h3F00

`endif

// ---- design/rpis_input_select.v ----
// Remappable peripheral input select registers with APB slave and pin routing
//
// Behaviour
// - Capture six from register nine high field
// - Capture five from register nine low field
// - Capture seven low field; upper bits unimplemented
// - Fault B from fault register high field
// - Fault A from fault register low field
// - Serial3 receive high field; low byte unimplemented
// - Serial1 clear-to-send from high field
// - Serial1 receive from low field
// - Serial2 clear-to-send from high field
// - Serial2 receive from low field
// - SPI1 clock input from high field
// - SPI1 data input from low field
// - Serial3 clear-to-send from last register high
// - SPI1 slave select from last register low
// - Unimplemented bits ignore writes, read zero
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "rpis_defines.vh"

module rpis_input_select #(
  parameter NUM_PINS  = 48,          // Remappable pins present
  parameter IDLE_LVL  = 1'b0         // Level of an unconnected input
) (
  input  wire                pclk,                   // APB clock
  input  wire                presetn,                // APB reset, active low
  input  wire                psel,                   // APB select
  input  wire                penable,                // APB access phase
  input  wire                pwrite,                 // APB write
  input  wire [11:0]         paddr,                  // APB byte address
  input  wire [31:0]         pwdata,                 // APB write data
  input  wire [3:0]          pstrb,                  // APB byte strobes
  output wire                pready,                 // APB ready
  output reg  [31:0]         prdata,                 // APB read data
  output wire                pslverr,                // APB error
  input  wire [NUM_PINS-1:0] remappable_io_pin,      // Remappable pin levels
  output reg                 capture_channel_five,   // Capture 5 input
  output reg                 capture_channel_six,    // Capture 6 input
  output reg                 capture_channel_seven,  // Capture 7 input
  output reg                 compare_fault_a,        // Compare fault A
  output reg                 compare_fault_b,        // Compare fault B
  output reg                 serial3_receive,        // Serial 3 receive
  output reg                 serial1_clear_to_send,  // Serial 1 CTS
  output reg                 serial1_receive,        // Serial 1 receive
  output reg                 serial2_clear_to_send,  // Serial 2 CTS
  output reg                 serial2_receive,        // Serial 2 receive
  output reg                 spi1_clock_in,          // SPI1 clock in
  output reg                 spi1_data_in,           // SPI1 data in
  output reg                 serial3_clear_to_send,  // Serial 3 CTS
  output reg                 spi1_slave_select_in    // SPI1 slave select in
);

  // ****************************************
  // Selection fields
  // ****************************************
  reg [5:0] capture_five_pin_sel_q;
  reg [5:0] capture_six_pin_sel_q;
  reg [5:0] capture_seven_pin_sel_q;
  reg [5:0] fault_a_pin_sel_q;
  reg [5:0] fault_b_pin_sel_q;
  reg [5:0] serial3_rx_pin_sel_q;
  reg [5:0] serial1_cts_pin_sel_q;
  reg [5:0] serial1_rx_pin_sel_q;
  reg [5:0] serial2_cts_pin_sel_q;
  reg [5:0] serial2_rx_pin_sel_q;
  reg [5:0] spi1_clock_pin_sel_q;
  reg [5:0] spi1_data_in_pin_sel_q;
  reg [5:0] serial3_cts_pin_sel_q;
  reg [5:0] spi1_select_pin_sel_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire       wr_en;
  wire       rd_en;
  wire       hit;
  wire [5:0] wr_lo;
  wire [5:0] wr_hi;
  reg        hit_r;
  wire       at_cap56;
  wire       at_cap7;
  wire       at_fault;
  wire       at_ser3rx;
  wire       at_ser1;
  wire       at_ser2;
  wire       at_spi1cd;
  wire       at_ser3spi;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite;
  // Setup phase, so read data already stands at the access edge
  assign rd_en   = psel & ~penable & ~pwrite;
  assign wr_lo   = pwdata[`RPIS_LO_MSB:`RPIS_LO_LSB];
  assign wr_hi   = pwdata[`RPIS_HI_MSB:`RPIS_HI_LSB];

  assign at_cap56   = (paddr == `RPIS_ADDR_CAP56);
  assign at_cap7    = (paddr == `RPIS_ADDR_CAP7);
  assign at_fault   = (paddr == `RPIS_ADDR_FAULT);
  assign at_ser3rx  = (paddr == `RPIS_ADDR_SER3RX);
  assign at_ser1    = (paddr == `RPIS_ADDR_SER1);
  assign at_ser2    = (paddr == `RPIS_ADDR_SER2);
  assign at_spi1cd  = (paddr == `RPIS_ADDR_SPI1CD);
  assign at_ser3spi = (paddr == `RPIS_ADDR_SER3SPI);

  always @* begin
    case (paddr)
      `RPIS_ADDR_CAP56, `RPIS_ADDR_CAP7, `RPIS_ADDR_FAULT, `RPIS_ADDR_SER3RX,
      `RPIS_ADDR_SER1, `RPIS_ADDR_SER2, `RPIS_ADDR_SPI1CD, `RPIS_ADDR_SER3SPI: hit_r = 1'b1;
      default: hit_r = 1'b0;
    endcase
  end
  assign hit = hit_r;

  // ****************************************
  // Register writes
  // ****************************************
  // Only implemented bits are stored; the rest are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_five_pin_sel_q <= `RPIS_SEL_RST;
      capture_six_pin_sel_q  <= `RPIS_SEL_RST;
    end else if (wr_en && at_cap56) begin
      if (pstrb[0]) capture_five_pin_sel_q <= wr_lo;
      if (pstrb[1]) capture_six_pin_sel_q <= wr_hi;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_seven_pin_sel_q <= `RPIS_SEL_RST;
    end else if (wr_en && at_cap7) begin
      if (pstrb[0]) capture_seven_pin_sel_q <= wr_lo;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_a_pin_sel_q <= `RPIS_SEL_RST;
      fault_b_pin_sel_q <= `RPIS_SEL_RST;
    end else if (wr_en && at_fault) begin
      if (pstrb[0]) fault_a_pin_sel_q <= wr_lo;
      if (pstrb[1]) fault_b_pin_sel_q <= wr_hi;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial3_rx_pin_sel_q <= `RPIS_SEL_RST;
    end else if (wr_en && at_ser3rx) begin
      if (pstrb[1]) serial3_rx_pin_sel_q <= wr_hi;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial1_rx_pin_sel_q  <= `RPIS_SEL_RST;
      serial1_cts_pin_sel_q <= `RPIS_SEL_RST;
    end else if (wr_en && at_ser1) begin
      if (pstrb[0]) serial1_rx_pin_sel_q <= wr_lo;
      if (pstrb[1]) serial1_cts_pin_sel_q <= wr_hi;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial2_rx_pin_sel_q  <= `RPIS_SEL_RST;
      serial2_cts_pin_sel_q <= `RPIS_SEL_RST;
    end else if (wr_en && at_ser2) begin
      if (pstrb[0]) serial2_rx_pin_sel_q <= wr_lo;
      if (pstrb[1]) serial2_cts_pin_sel_q <= wr_hi;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi1_data_in_pin_sel_q <= `RPIS_SEL_RST;
      spi1_clock_pin_sel_q   <= `RPIS_SEL_RST;
    end else if (wr_en && at_spi1cd) begin
      if (pstrb[0]) spi1_data_in_pin_sel_q <= wr_lo;
      if (pstrb[1]) spi1_clock_pin_sel_q <= wr_hi;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi1_select_pin_sel_q <= `RPIS_SEL_RST;
      serial3_cts_pin_sel_q <= `RPIS_SEL_RST;
    end else if (wr_en && at_ser3spi) begin
      if (pstrb[0]) spi1_select_pin_sel_q <= wr_lo;
      if (pstrb[1]) serial3_cts_pin_sel_q <= wr_hi;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  function [15:0] pack;
    input [5:0] hi;
    input [5:0] lo;
    begin
      pack = {2'b00, hi, 2'b00, lo};
    end
  endfunction

  wire [15:0] word_cap56;
  wire [15:0] word_cap7;
  wire [15:0] word_fault;
  wire [15:0] word_ser3rx;
  wire [15:0] word_ser1;
  wire [15:0] word_ser2;
  wire [15:0] word_spi1cd;
  wire [15:0] word_ser3spi;

  assign word_cap56   = pack(capture_six_pin_sel_q, capture_five_pin_sel_q);
  assign word_cap7    = pack(6'h00, capture_seven_pin_sel_q);
  assign word_fault   = pack(fault_b_pin_sel_q, fault_a_pin_sel_q);
  assign word_ser3rx  = pack(serial3_rx_pin_sel_q, 6'h00);
  assign word_ser1    = pack(serial1_cts_pin_sel_q, serial1_rx_pin_sel_q);
  assign word_ser2    = pack(serial2_cts_pin_sel_q, serial2_rx_pin_sel_q);
  assign word_spi1cd  = pack(spi1_clock_pin_sel_q, spi1_data_in_pin_sel_q);
  assign word_ser3spi = pack(serial3_cts_pin_sel_q, spi1_select_pin_sel_q);

  reg [15:0] rd_word;
  always @* begin
    case (paddr)
      `RPIS_ADDR_CAP56:   rd_word = word_cap56;
      `RPIS_ADDR_CAP7:    rd_word = word_cap7;
      `RPIS_ADDR_FAULT:   rd_word = word_fault;
      `RPIS_ADDR_SER3RX:  rd_word = word_ser3rx;
      `RPIS_ADDR_SER1:    rd_word = word_ser1;
      `RPIS_ADDR_SER2:    rd_word = word_ser2;
      `RPIS_ADDR_SPI1CD:  rd_word = word_spi1cd;
      `RPIS_ADDR_SER3SPI: rd_word = word_ser3spi;
      default:            rd_word = 16'h0000;
    endcase
  end

  // Read data registered at the setup edge, held through the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= hit ? {16'h0000, rd_word} : 32'h00000000;
    end
  end

  // ****************************************
  // Pin routing
  // ****************************************
  function pick;
    input [NUM_PINS-1:0] pins;
    input [5:0]          sel;
    begin
      if (sel < NUM_PINS)
        pick = pins[sel];
      else
        pick = IDLE_LVL;
    end
  endfunction

  // Each input is retimed once, so a new selection shows one edge later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_channel_five <= IDLE_LVL;
    end else begin
      capture_channel_five <= pick(remappable_io_pin, capture_five_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_channel_six <= IDLE_LVL;
    end else begin
      capture_channel_six <= pick(remappable_io_pin, capture_six_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_channel_seven <= IDLE_LVL;
    end else begin
      capture_channel_seven <= pick(remappable_io_pin, capture_seven_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_fault_a <= IDLE_LVL;
    end else begin
      compare_fault_a <= pick(remappable_io_pin, fault_a_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_fault_b <= IDLE_LVL;
    end else begin
      compare_fault_b <= pick(remappable_io_pin, fault_b_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial3_receive <= IDLE_LVL;
    end else begin
      serial3_receive <= pick(remappable_io_pin, serial3_rx_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial1_clear_to_send <= IDLE_LVL;
    end else begin
      serial1_clear_to_send <= pick(remappable_io_pin, serial1_cts_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial1_receive <= IDLE_LVL;
    end else begin
      serial1_receive <= pick(remappable_io_pin, serial1_rx_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial2_clear_to_send <= IDLE_LVL;
    end else begin
      serial2_clear_to_send <= pick(remappable_io_pin, serial2_cts_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial2_receive <= IDLE_LVL;
    end else begin
      serial2_receive <= pick(remappable_io_pin, serial2_rx_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi1_clock_in <= IDLE_LVL;
    end else begin
      spi1_clock_in <= pick(remappable_io_pin, spi1_clock_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi1_data_in <= IDLE_LVL;
    end else begin
      spi1_data_in <= pick(remappable_io_pin, spi1_data_in_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial3_clear_to_send <= IDLE_LVL;
    end else begin
      serial3_clear_to_send <= pick(remappable_io_pin, serial3_cts_pin_sel_q);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi1_slave_select_in <= IDLE_LVL;
    end else begin
      spi1_slave_select_in <= pick(remappable_io_pin, spi1_select_pin_sel_q);
    end
  end

endmodule

// ---- sim/rpis_input_select_sva.sv ----
// Port assertions for the remappable input select block
`timescale 1ns/1ps
`include "rpis_defines.vh"
module rpis_input_select_sva #(
  parameter NUM_PINS = 48,
  parameter IDLE_LVL = 1'b0
) (
  input wire                pclk,                  // Clock
  input wire                presetn,               // Reset
  input wire                psel,                  // Select
  input wire                penable,               // Enable
  input wire                pwrite,                // Write
  input wire [11:0]         paddr,                 // Address
  input wire [31:0]         pwdata,                // Write data
  input wire [3:0]          pstrb,                 // Strobes
  input wire                pready,                // Ready
  input wire [31:0]         prdata,                // Read data
  input wire                pslverr,               // Error
  input wire [NUM_PINS-1:0] remappable_io_pin,     // Pins
  input wire                capture_channel_five,  // Capture 5
  input wire                capture_channel_six    // Capture 6
);
  // ****
  // Shadow of the capture select register
  // ****
  reg  [5:0] hi_q;
  reg  [5:0] lo_q;
  wire       wr_cap = psel && penable && pwrite && paddr == `RPIS_ADDR_CAP56;
  wire       exp_five = (lo_q < NUM_PINS) ? remappable_io_pin[lo_q] : IDLE_LVL;
  wire       exp_six = (hi_q < NUM_PINS) ? remappable_io_pin[hi_q] : IDLE_LVL;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q <= `RPIS_SEL_RST;
      lo_q <= `RPIS_SEL_RST;
    end else if (wr_cap) begin
      if (pstrb[1]) hi_q <= pwdata[13:8];
      if (pstrb[0]) lo_q <= pwdata[5:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  property p_ready; pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("bus answer wrong");
  property p_pad; (prdata & 32'hFFFF_C0C0) == 32'h0000_0000; endproperty
  a_pad: assert property (p_pad) else $error("unused read bits set");
  property p_cap7; s_rd(`RPIS_ADDR_CAP7) |-> prdata[15:6] == 10'h000; endproperty
  a_cap7: assert property (p_cap7) else $error("capture seven upper bits set");
  property p_s3rx; s_rd(`RPIS_ADDR_SER3RX) |-> prdata[7:0] == 8'h00; endproperty
  a_s3rx: assert property (p_s3rx) else $error("serial3 receive low byte set");
  property p_cap_rd; s_rd(`RPIS_ADDR_CAP56) |-> prdata[15:0] == {2'b00, hi_q, 2'b00, lo_q}; endproperty
  a_cap_rd: assert property (p_cap_rd) else $error("capture select readback wrong");
  property p_unmap; s_rd(12'h030) |-> prdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_five; capture_channel_five == $past(exp_five); endproperty
  a_five: assert property (p_five) else $error("capture five routing wrong");
  property p_six; capture_channel_six == $past(exp_six); endproperty
  a_six: assert property (p_six) else $error("capture six routing wrong");
endmodule
bind rpis_input_select rpis_input_select_sva #(.NUM_PINS(NUM_PINS), .IDLE_LVL(IDLE_LVL)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .remappable_io_pin(remappable_io_pin), .capture_channel_five(capture_channel_five),
  .capture_channel_six(capture_channel_six));

// ---- sim/rpis_pin_model.sv ----
// Remappable pin drivers on the far side of the select block
`timescale 1ns/1ps
module rpis_pin_model (
  input  wire        pclk,     // Clock
  input  wire        presetn,  // Reset, active low
  output reg  [47:0] pins_q    // Pin levels
);
  // Pattern moves every cycle so stale routing shows
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= 48'h5A3C_C3A5_96E1;
    end else begin
      pins_q <= {pins_q[46:0], pins_q[47] ^ pins_q[42]};
    end
  end
endmodule

// ---- sim/test_remappable_input_select_regs.sv ----
// Self-checking bench for the remappable input select block
`timescale 1ns/1ps
`include "rpis_defines.vh"
module test_remappable_input_select_regs;
  localparam [31:0] HI_O = 32'hCA86_54F1;
  localparam [31:0] LO_O = 32'hDB97_F320;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg  [3:0]  pstrb = 4'h0;
  wire        pready;
  wire [31:0] prdata;
  wire        pslverr;
  wire [47:0] pins;
  wire [13:0] outs;
  reg  [47:0] pins_edge;
  reg  [31:0] rd;
  reg  [5:0]  sel [0:15];
  integer     miscompares = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     r;
  integer     j;
  rpis_input_select dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .remappable_io_pin(pins), .capture_channel_five(outs[0]), .capture_channel_six(outs[1]),
    .capture_channel_seven(outs[2]), .compare_fault_a(outs[3]), .compare_fault_b(outs[4]),
    .serial3_receive(outs[5]), .serial1_clear_to_send(outs[6]), .serial1_receive(outs[7]),
    .serial2_clear_to_send(outs[8]), .serial2_receive(outs[9]), .spi1_clock_in(outs[10]),
    .spi1_data_in(outs[11]), .serial3_clear_to_send(outs[12]), .spi1_slave_select_in(outs[13]));
  rpis_pin_model pm (.pclk(pclk), .presetn(presetn), .pins_q(pins));
  // ****
  // Bus, compare and report tasks
  // ****
  function [11:0] ra(input integer k);
    ra = (k < 3) ? `RPIS_ADDR_CAP56 + 12'(4 * k) : `RPIS_ADDR_SER3RX + 12'(4 * (k - 3));
  endfunction
  function [15:0] rm(input integer k);
    rm = (k == 1) ? `RPIS_MASK_LO : (k == 3) ? `RPIS_MASK_HI : `RPIS_MASK_BOTH;
  endfunction
  function [31:0] rw(input integer k);
    reg [3:0] h;
    reg [3:0] l;
    begin
      h = HI_O[4*k +: 4];
      l = LO_O[4*k +: 4];
      rw = {18'h3FFFF, (h == 4'hF) ? 6'h3F : sel[h], 2'b11, (l == 4'hF) ? 6'h3F : sel[l]};
    end
  endfunction
  task apb(input reg wr, input reg [11:0] a, input reg [31:0] d, input reg [3:0] s);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task chk(input string nm, input reg [31:0] exp, input reg [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task chk_route;
    begin
      @(posedge pclk);
      @(negedge pclk);
      for (j = 0; j < 14; j = j + 1)
        chk("route", {31'h0, (sel[j] < 48) ? pins_edge[sel[j]] : 1'b0}, {31'h0, outs[j]});
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    pins_edge <= pins;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    for (j = 0; j < 16; j = j + 1) sel[j] = `RPIS_SEL_RST;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (r = 0; r < 8; r = r + 1) begin
      apb(1'b0, ra(r), 32'h0, 4'h0);
      chk("reset", {16'h0, rm(r)}, rd);
    end
    chk_route;
    for (j = 0; j < 14; j = j + 1) sel[j] = 6'(3 * j + 1);
    for (r = 0; r < 8; r = r + 1) begin
      apb(1'b1, ra(r), rw(r), 4'hF);
      apb(1'b0, ra(r), 32'h0, 4'h0);
      chk("readback", {16'h0, rw(r) & {16'h0, rm(r)}}, rd);
    end
    repeat (3) chk_route;
    sel[1] = 6'h00;
    apb(1'b1, `RPIS_ADDR_CAP56, 32'h0, 4'b0010);
    apb(1'b0, `RPIS_ADDR_CAP56, 32'h0, 4'h0);
    chk("strobe", 32'h0000_0001, rd);
    sel[0] = 6'd48;
    sel[1] = 6'd47;
    apb(1'b1, `RPIS_ADDR_CAP56, rw(0), 4'hF);
    repeat (2) chk_route;
    apb(1'b1, 12'h030, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, 12'h030, 32'h0, 4'h0);
    chk("unmapped", 32'h0, rd);
    apb(1'b0, `RPIS_ADDR_CAP56, 32'h0, 4'h0);
    chk("keep", 32'h0000_2F30, rd);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (j = 0; j < 14; j = j + 1) sel[j] = `RPIS_SEL_RST;
    apb(1'b0, ra(4), 32'h0, 4'h0);
    chk("rereset", {16'h0, rm(4)}, rd);
    chk_route;
    final_report;
  end
endmodule
